// file: core/octal_driver_fault_latch.sv
// Fault detection, latching, clearing and reporting core of the eight channel driver.
`timescale 1ns/10ps

// Summary of operation
// - Open load reports only when its diagnostic is enabled and the condition exists.
// - Open load is never latched and never reported while the driver is on.
// - Open load is captured into the fault word when chip select falls.
// - A channel is off when its enable bit and parallel input are both 0.
// - Over current is reported whenever the channel's detector is active.
// - A driver latches off after over current persists for the filter time.
// - A valid frame with enable 0 clears over current; next frame may turn on.
// - Thermal warning shows in fault word bit 0; outputs stay on.
// - Thermal warning is sampled and presented only while chip select is low.
// - Thermal shutdown turns off and latches both drivers of its pair.
// - Shutdown latch clears after flag release plus valid frame with enables 0.
// - Supply over or under voltage sets and latches fault word bit 15.
// - All drivers are forced off while the supply fault is present.
// - On supply recovery drivers resume the last valid frame's command.
// - Any valid frame clears the latched supply fail bit.
// - That clear only takes effect while the supply is within limits.
// - Device enable low turns all outputs off and clears all state but the synchronisers.
module octal_driver_fault_latch
  import drv_pkg::*;
#(
  parameter int FILTER_CYCLES = drv_pkg::OC_FILTER_CYCLES
)
(
  // Core clock and reset.
  input  wire logic                          clk,
  input  wire logic                          srst,
  // Serial link from the host.
  input  wire logic                          sclk,
  input  wire logic                          chip_select_n,
  input  wire logic                          si,
  output logic                               so_data,
  output logic                               so_oe,
  // Sensor flags and pins.
  input  drv_pkg::sense_t                    sense_in,
  // Driver commands and fault status.
  output logic [drv_pkg::NUM_CH-1:0]         drive_on,
  output logic [drv_pkg::FRAME_BITS-1:0]     fault_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Whole state of the core in one record.
  typedef struct packed {
    sense_t                          sync1;
    sense_t                          sync2;
    logic                            cs1;
    logic                            cs2;
    logic                            cs3;
    logic [NUM_CH-1:0]               en;
    logic [NUM_CH-1:0]               ol_en;
    logic [NUM_CH-1:0]               oc_latch;
    logic [NUM_CH-1:0]               tsd_latch;
    logic [NUM_CH-1:0]               drive;
    logic                            psf_latch;
    logic [FRAME_BITS-1:0]           tx;
    logic [NUM_CH-1:0][FILT_W-1:0]   oc_cnt;
  } state_t;

  localparam state_t STATE_RST = '0;
  localparam logic [FILT_W-1:0] OC_LAST = FILT_W'(FILTER_CYCLES - 1);

  state_t                q;
  state_t                d;
  sense_t                s;
  link_rx_t              rx;
  cmd_frame_t            cmd;
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  frame_valid;
  logic [NUM_CH-1:0]     par_vec;
  logic [NUM_CH-1:0]     cmd_on;
  logic [NUM_CH-1:0]     ol_rep;
  logic [NUM_CH-1:0]     oc_run;
  logic [NUM_CH-1:0]     oc_hit;
  logic [NUM_CH-1:0]     tsd_now;
  logic [NUM_CH-1:0]     status_vec;
  logic [FRAME_BITS-1:0] word_now;

  ////////////////////////////////////////////////////////////////////////////
  // Spread one flag per driver pair onto both drivers of the pair.
  function automatic logic [NUM_CH-1:0] pair_expand(input logic [NUM_PAIR-1:0] p);
    logic [NUM_CH-1:0] r;
    r = '0;
    for (int k = 0; k < NUM_CH; k++)
      r[k] = p[k/2];
    return r;
  endfunction : pair_expand

  ////////////////////////////////////////////////////////////////////////////
  // Serial link on the host clock.
  spi_link u_link (
    .sclk          (sclk),
    .chip_select_n (chip_select_n),
    .si            (si),
    .so_data       (so_data),
    .so_oe         (so_oe),
    .tx_word       (q.tx),
    .rx            (rx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Only the second synchroniser stage feeds the logic.
  assign s = q.sync2;

  // Chip select edges seen after synchronisation; the link word is stable while select is high.
  assign cs_fall     = q.cs3 & ~q.cs2;
  assign cs_rise     = ~q.cs3 & q.cs2;
  assign frame_valid = cs_rise & rx.frame_ok;
  assign cmd         = cmd_frame_t'(rx.rx_word);

  // Parallel inputs serve the upper channels only.
  assign par_vec = {s.parallel_drive_input, {(NUM_CH-NUM_PAR){1'b0}}};
  assign cmd_on  = q.en | par_vec;

  // Open load is live only for an enabled channel that is commanded off.
  assign ol_rep = q.ol_en & s.open_load & ~cmd_on & {NUM_CH{~s.supply_fail_flag}};

  // Over current is timed only while the driver is on.
  assign oc_run  = s.over_cur & q.drive;
  assign tsd_now = pair_expand(s.therm_shut);

  // Per channel status: live over current, latched faults and open load.
  assign status_vec = ol_rep | s.over_cur | q.oc_latch | q.tsd_latch;

  // Fault word as it would be captured now.
  assign word_now = {q.psf_latch, {PAD_BITS{1'b0}}, status_vec, s.thermal_warn_flag};

  // Filter end for each channel.
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
      oc_hit[i] = oc_run[i] & (q.oc_cnt[i] == OC_LAST);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the core.
  always_comb
  begin
    d = q;

    // Two stage synchronisers for the sensor flags, pins and chip select.
    d.sync1 = sense_in;
    d.sync2 = q.sync1;
    d.cs1   = chip_select_n;
    d.cs2   = q.cs1;
    d.cs3   = q.cs2;

    // A valid frame stores the new command.
    if (frame_valid)
    begin
      d.en    = cmd.channel_enable_bit;
      d.ol_en = cmd.ol_enable;
    end

    for (int i = 0; i < NUM_CH; i++)
    begin
      // Filter counter runs while over current persists on an active driver.
      if (oc_run[i] && !oc_hit[i])
        d.oc_cnt[i] = q.oc_cnt[i] + FILT_W'(1);
      else
        d.oc_cnt[i] = '0;

      // Clear by a frame with enable 0; a filter end in the same cycle wins.
      if (frame_valid && !cmd.channel_enable_bit[i])
        d.oc_latch[i] = 1'b0;
      if (oc_hit[i])
        d.oc_latch[i] = 1'b1;

      // Shutdown latch clears only with the pair flag released.
      if (frame_valid && !cmd.channel_enable_bit[i] && !tsd_now[i])
        d.tsd_latch[i] = 1'b0;
      if (tsd_now[i])
        d.tsd_latch[i] = 1'b1;
    end

    // Supply fail clears on any valid frame only when the supply is good.
    if (frame_valid && !s.supply_fail_flag)
      d.psf_latch = 1'b0;
    if (s.supply_fail_flag)
      d.psf_latch = 1'b1;

    // Drivers follow the stored command unless a fault holds them off.
    d.drive = cmd_on & ~d.oc_latch & ~d.tsd_latch & {NUM_CH{~s.supply_fail_flag}};

    // Whole word captured at the select fall; warning bit kept live while select is low.
    if (cs_fall)
      d.tx = word_now;
    else if (!q.cs2)
      d.tx[TW_BIT] = s.thermal_warn_flag;

    // Enable low clears everything but the synchronisers.
    if (!s.dev_enable)
    begin
      d       = STATE_RST;
      d.sync1 = sense_in;
      d.sync2 = q.sync1;
      d.cs1   = chip_select_n;
      d.cs2   = q.cs1;
      d.cs3   = q.cs2;
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      // Select stages start at the idle level so no false edge follows reset.
      q     <= STATE_RST;
      q.cs1 <= 1'b1;
      q.cs2 <= 1'b1;
      q.cs3 <= 1'b1;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register.
  assign drive_on   = q.drive;
  assign fault_word = q.tx;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the core behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence supply_back_s;
    s.supply_fail_flag ##1 !s.supply_fail_flag;
  endsequence

  sequence enabled_s;
    s.dev_enable && $past(s.dev_enable);
  endsequence

  a_ol_capture_word: assert property (cs_fall && s.dev_enable |=> q.tx == $past(word_now))
    else $error("Fault word not captured at select fall.");

  a_ol_not_on: assert property (cs_fall && s.dev_enable && cmd_on[0] && !s.over_cur[0]
                                && q.oc_latch[0] == 1'b0 && q.tsd_latch[0] == 1'b0
                                |=> !q.tx[STAT_LSB])
    else $error("Open load reported for an active channel.");

  a_oc_latch_time: assert property (oc_hit[0] && s.dev_enable |=> q.oc_latch[0] && !q.drive[0])
    else $error("Over current latch missed at filter end.");

  a_oc_frame_clear: assert property (frame_valid && !cmd.channel_enable_bit[0] && !oc_hit[0] && s.dev_enable
                                     |=> !q.oc_latch[0] ##1 !q.drive[0] || q.en[0] == 1'b0)
    else $error("Over current latch not cleared by frame.");

  a_tsd_pair_off: assert property (s.therm_shut[0] && s.dev_enable
                                   |=> q.tsd_latch[1:0] == 2'b11 && q.drive[1:0] == 2'b00)
    else $error("Thermal shutdown did not latch the pair off.");

  a_tsd_hold_flag: assert property (q.tsd_latch[2] && s.therm_shut[1] && s.dev_enable |=> q.tsd_latch[2])
    else $error("Shutdown latch cleared while flag active.");

  a_tw_live_low: assert property (!q.cs2 && !cs_fall && s.dev_enable
                                  |=> q.tx[TW_BIT] == $past(s.thermal_warn_flag))
    else $error("Warning bit not live while select low.");

  a_psf_all_off: assert property (s.supply_fail_flag && s.dev_enable
                                  |=> q.psf_latch && q.drive == '0 ##1 q.psf_latch)
    else $error("Supply fail did not force drivers off.");

  a_psf_clear_any: assert property (frame_valid && !s.supply_fail_flag && s.dev_enable |=> !q.psf_latch)
    else $error("Supply fail bit not cleared by valid frame.");

  a_psf_keep_bad: assert property (frame_valid && s.supply_fail_flag |=> q.psf_latch || !$past(s.dev_enable))
    else $error("Supply fail bit cleared while supply bad.");

  a_supply_resume: assert property (supply_back_s ##0 enabled_s
                                    |=> q.drive == ($past(cmd_on) & ~q.oc_latch & ~q.tsd_latch))
    else $error("Drivers did not resume command after supply recovery.");

  a_enable_low_clr: assert property (!s.dev_enable |=> q.drive == '0 && q.en == '0 && q.tx == FAULT_WORD_RST)
    else $error("Enable low did not clear the core.");
endmodule : octal_driver_fault_latch

// file: core/drv_pkg.sv
// Shared constants and types for the octal driver fault latch.
package drv_pkg;
  // Channel organisation.
  localparam int NUM_CH     = 8;
  localparam int NUM_PAIR   = 4;
  localparam int NUM_PAR    = 4;
  localparam int FRAME_BITS = 16;
  localparam int BIT_CNT_W  = 4;

  // Timing: over current filter time and its cycle count at the core clock.
  localparam int CLK_PERIOD_NS    = 40;
  localparam int OC_FILTER_NS     = 100000;
  localparam int OC_FILTER_CYCLES = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_W           = 12;

  // Field positions in the command frame and in the fault word.
  localparam int EN_LSB    = 0;
  localparam int OL_EN_LSB = 8;
  localparam int TW_BIT    = 0;
  localparam int STAT_LSB  = 1;
  localparam int PSF_BIT   = 15;
  localparam int PAD_BITS  = PSF_BIT - STAT_LSB - NUM_CH;

  // Reset values.
  localparam logic [FRAME_BITS-1:0] FAULT_WORD_RST = 16'h0000;

  // Command frame as received, enables in the low byte.
  typedef struct packed {
    logic [NUM_CH-1:0] ol_enable;
    logic [NUM_CH-1:0] channel_enable_bit;
  } cmd_frame_t;

  // Sensor flags and pins that enter the core clock domain.
  typedef struct packed {
    logic [NUM_CH-1:0]   over_cur;
    logic [NUM_CH-1:0]   open_load;
    logic [NUM_PAIR-1:0] therm_shut;
    logic                thermal_warn_flag;
    logic                supply_fail_flag;
    logic                dev_enable;
    logic [NUM_PAR-1:0]  parallel_drive_input;
  } sense_t;

  // Received frame handed from the link to the core.
  typedef struct packed {
    logic [FRAME_BITS-1:0] rx_word;
    logic                  frame_ok;
  } link_rx_t;

  // State of the serial link logic.
  typedef struct packed {
    logic [FRAME_BITS-1:0] shift;
    logic [BIT_CNT_W-1:0]  bits;
    logic                  any;
  } link_state_t;

  localparam link_state_t LINK_RST = '0;
endpackage : drv_pkg

// file: core/spi_link.sv
// Serial link shifter running on the host serial clock.
`timescale 1ns/10ps
module spi_link
  import drv_pkg::*;
(
  // Serial link pins.
  input  wire logic                        sclk,
  input  wire logic                        chip_select_n,
  input  wire logic                        si,
  output logic                             so_data,
  output logic                             so_oe,
  // Core side.
  input  wire logic [drv_pkg::FRAME_BITS-1:0] tx_word,
  output drv_pkg::link_rx_t                rx
);

  link_state_t q;
  link_state_t d;
  link_rx_t    held;

  ////////////////////////////////////////////////////////////////////////////
  // Data is taken least significant bit first on the rising serial clock.
  always_comb
  begin
    d       = q;
    d.shift = {si, q.shift[FRAME_BITS-1:1]};
    d.bits  = q.bits + BIT_CNT_W'(1);
    d.any   = 1'b1;
  end

  // Chip select high holds the shifter cleared, so no serial clock edge is needed to end a frame.
  always_ff @(posedge sclk or posedge chip_select_n)
  begin
    if (chip_select_n)
      q <= LINK_RST;
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // A frame is good when a non-zero whole multiple of sixteen bits was clocked in.
  // The result is taken as select rises, before the shifter clears, and stands until the next rise,
  // so the core can read it safely after its own synchronised view of the select edge.
  always_ff @(posedge chip_select_n)
  begin
    held.rx_word  <= q.shift;
    held.frame_ok <= q.any & (q.bits == '0);
  end

  assign rx = held;

  // The next bit to send is picked by the bit count; bit zero shows as soon as select falls.
  assign so_data = tx_word[q.bits];
  assign so_oe   = ~chip_select_n;
endmodule : spi_link

// file: verif/host_spi_model.sv
// Host controller model that plays the serial master toward the driver.
`timescale 1ns/10ps
module host_spi_model
(
  // Serial link pins.
  output logic      sclk,
  output logic      chip_select_n,
  output logic      si,
  input  wire logic so_data
);
  // Idle levels: select high, serial clock standing still.
  initial
  begin
    sclk          = 1'b0;
    chip_select_n = 1'b1;
    si            = 1'b0;
  end

  // One frame of nbits, LSB first; a count of zero only peeks at bit 0.
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rd);
    int i;
    rd            = 16'hXXXX;
    si            = word[0];
    chip_select_n = 1'b0;
    #213;
    rd[0] = so_data;
    for (i = 0; i < nbits; i++)
    begin
      rd[i % 16] = so_data;
      sclk       = 1'b1;
      #40;
      sclk = 1'b0;
      si   = word[(i + 1) % 16];
      #40;
    end
    chip_select_n = 1'b1;
    si            = ~si;
    #200;
  endtask : xfer
endmodule : host_spi_model

// file: verif/octal_driver_fault_latch_tb_top.sv
// Self-checking bench for the octal driver fault latch with a serial host model.
`timescale 1ns/10ps
module octal_driver_fault_latch_tb_top;
  import drv_pkg::*;
  localparam int FILT = 8;
  logic        clk;
  logic        srst;
  logic        sclk;
  logic        chip_select_n;
  logic        si;
  logic        so_data;
  logic        so_oe;
  sense_t      sense;
  logic [7:0]  drive_on;
  logic [15:0] fault_word;
  logic [15:0] rd;
  logic [15:0] w;
  logic [7:0]  en_prev;
  logic [7:0]  ol_prev;
  logic [3:0]  par;
  int          error_cnt;
  int          total_checks;
  int          seed;
  int          k;

  ////////////////////////////////////////////////////////////////////////////////
  // Design, host model and clock.
  octal_driver_fault_latch #(.FILTER_CYCLES(FILT)) uut (.clk(clk), .srst(srst), .sclk(sclk),
    .chip_select_n(chip_select_n), .si(si), .so_data(so_data), .so_oe(so_oe), .sense_in(sense),
    .drive_on(drive_on), .fault_word(fault_word));
  host_spi_model host (.sclk(sclk), .chip_select_n(chip_select_n), .si(si), .so_data(so_data));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic frame(input logic [15:0] word, input int nbits);
    host.xfer(word, nbits, rd);
    tick(3);
  endtask : frame

  function automatic logic [7:0] exp_on(input logic [7:0] en, input logic [3:0] p);
    return en | {p, 4'h0};
  endfunction : exp_on

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // Watchdog well beyond the expected run length.
  initial
  begin
    #1000000;
    error_cnt++;
    $display("unexpected at %0t: run hung", $time);
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence.
  initial
  begin
    seed         = 32'h001AB720;
    error_cnt    = 0;
    total_checks = 0;
    sense        = '0;
    sense.dev_enable = 1'b1;
    srst         = 1'b1;
    tick(3);
    srst = 1'b0;
    tick(4);
    check({8'h00, drive_on}, 16'h0000, "reset drive");
    check(fault_word, 16'h0000, "reset fault word");
    // Open load against random commands and parallel inputs.
    en_prev = 8'h00;
    ol_prev = 8'h00;
    for (k = 0; k < 8; k++)
    begin
      w   = (k == 0) ? 16'hFF00 : 16'($random(seed));
      par = (k == 1) ? 4'h0 : 4'($random(seed));
      sense.parallel_drive_input = par;
      sense.open_load = (k == 1) ? 8'hFF : 8'($random(seed));
      tick(4);
      frame(w, 16);
      check({8'h00, rd[8:1]}, {8'h00, ol_prev & sense.open_load & ~exp_on(en_prev, par)}, "open load");
      check(fault_word, rd, "captured word");
      check({8'h00, drive_on}, {8'h00, exp_on(w[7:0], par)}, "command");
      en_prev = w[7:0];
      ol_prev = w[15:8];
    end
    sense.open_load = 8'h00;
    sense.parallel_drive_input = 4'h0;
    $display("test open_load done");
    // Thermal warning leaves outputs on and shows at select fall without clocks.
    frame(16'h00FF, 16);
    sense.thermal_warn_flag = 1'b1;
    tick(4);
    frame(16'h00FF, 0);
    check({15'h0000, rd[0]}, 16'h0001, "warn peek");
    frame(16'h00FF, 16);
    check({15'h0000, rd[0]}, 16'h0001, "warn bit");
    check({8'h00, drive_on}, 16'h00FF, "warn outputs");
    sense.thermal_warn_flag = 1'b0;
    tick(4);
    frame(16'h00FF, 0);
    check({15'h0000, rd[0]}, 16'h0000, "warn gone");
    $display("test thermal_warn done");
    // Over current filter, latch and clear.
    frame(16'h0001, 16);
    sense.over_cur = 8'h01;
    tick(5);
    check({8'h00, drive_on}, 16'h0001, "oc filtering");
    tick(FILT + 2);
    check({8'h00, drive_on}, 16'h0000, "oc latched off");
    sense.over_cur = 8'h00;
    tick(3);
    frame(16'h0001, 16);
    check({8'h00, rd[8:1]}, 16'h0001, "oc status");
    check({8'h00, drive_on}, 16'h0000, "oc held off");
    frame(16'h0000, 16);
    frame(16'h0001, 16);
    check({8'h00, rd[8:1]}, 16'h0000, "oc cleared");
    check({8'h00, drive_on}, 16'h0001, "oc back on");
    $display("test over_current done");
    // Thermal shutdown of pair one.
    frame(16'h000C, 16);
    sense.therm_shut = 4'h2;
    tick(4);
    check({8'h00, drive_on}, 16'h0000, "pair off");
    sense.therm_shut = 4'h0;
    tick(3);
    frame(16'h000C, 16);
    check({8'h00, rd[8:1]}, 16'h000C, "pair latched");
    check({8'h00, drive_on}, 16'h0000, "pair held");
    frame(16'h0000, 16);
    frame(16'h000C, 16);
    check({8'h00, rd[8:1]}, 16'h0000, "pair cleared");
    check({8'h00, drive_on}, 16'h000C, "pair on");
    $display("test thermal_shutdown done");
    // Supply fail forces off, latches and recovers.
    frame(16'h00A5, 16);
    sense.supply_fail_flag = 1'b1;
    tick(4);
    check({8'h00, drive_on}, 16'h0000, "supply off");
    frame(16'h005A, 16);
    check({15'h0000, rd[15]}, 16'h0001, "supply bit");
    check({8'h00, drive_on}, 16'h0000, "supply still off");
    sense.supply_fail_flag = 1'b0;
    tick(4);
    check({8'h00, drive_on}, 16'h005A, "supply resume");
    frame(16'h005A, 16);
    check({15'h0000, rd[15]}, 16'h0001, "supply kept");
    frame(16'h005A, 16);
    check({15'h0000, rd[15]}, 16'h0000, "supply cleared");
    $display("test supply_fail done");
    // Short frame refused, daisy chained frame accepted.
    frame(16'h0033, 15);
    check({8'h00, drive_on}, 16'h005A, "short frame");
    frame(16'h0033, 32);
    check({8'h00, drive_on}, 16'h0033, "long frame");
    // Device enable low clears everything but the synchronisers.
    frame(16'hFFFF, 16);
    sense.dev_enable = 1'b0;
    tick(4);
    check({8'h00, drive_on}, 16'h0000, "enable low");
    check(fault_word, 16'h0000, "enable low word");
    sense.dev_enable = 1'b1;
    tick(4);
    check({8'h00, drive_on}, 16'h0000, "enable back");
    $display("test enable done");
    close_out();
  end
endmodule : octal_driver_fault_latch_tb_top
